/* design/pbl_bit_pick.sv */
// Selects one operand bit from a fetched word and optionally inverts it.
`timescale 1ns/1ps
module pbl_bit_pick #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0]         data,    // Fetched operand word
  input  wire logic [$clog2(WIDTH)-1:0] sel,     // Bit index
  input  wire logic                     invert,  // Negated-status test
  output logic                          bit_out  // Selected status
);

  assign bit_out = data[sel] ^ invert;

endmodule

/* design/pbl_decoder.sv */
// Bit-logic and word exclusive-or instruction decoder and executor.
//
// Behaviour
// - 5100 XORs accumulator two into accumulator one.
// - True AND takes I/O, memory, S-bit ranges.
// - S-bit AND uses 780B and 784B.
// - S-bit OR uses 781B and 785B.
// - Timers and counters 0..127 give status.
// - Negated AND uses inverted operand status.
// - True OR ORs operand status in.
// - Negated OR ORs inverted status in.
// - FB00 ORs the preceding AND terms.
// - BA00 opens AND bracket, six deep.
// - BB00 opens OR bracket, six deep.
// - BF00 closes bracket, applies pending operation.
// - Formal AND only in blocks, bit type.
`timescale 1ns/1ps
module pbl_decoder (
  input  wire logic                        clk,          // 20 MHz clock
  input  wire logic                        rst_n,        // Async reset, active low
  input  wire logic                        instr_valid,  // Instruction word offered
  input  wire logic [pbl_pkg::WORD_W-1:0]  instr_word,   // Instruction word
  output logic                             instr_ready,  // Word is taken this cycle
  input  wire logic                        load_valid,   // Push a word into accumulators
  input  wire logic [pbl_pkg::WORD_W-1:0]  load_word,    // Word to load
  input  wire logic                        rlo_restart,  // Next term starts a new statement
  input  wire logic                        in_fb,        // Running inside a function block
  output logic                             rd_req,       // Operand read strobe
  output logic [2:0]                       rd_area,      // Operand area
  output logic [pbl_pkg::ADDR_W-1:0]       rd_addr,      // Byte, number or parameter
  input  wire logic [7:0]                  rd_data,      // Operand byte, one cycle later
  input  wire logic                        rd_bit_type,  // Formal parameter is bit type
  output logic                             logic_result, // Combined logic result
  output logic                             first_query,  // Next term starts the chain
  output logic [pbl_pkg::WORD_W-1:0]       accumulator1, // First accumulator
  output logic [pbl_pkg::WORD_W-1:0]       accumulator2, // Second accumulator
  output logic [2:0]                       nest_depth,   // Open brackets
  output logic                             instr_error   // Refused instruction, one pulse
);

  pbl_pkg::pbl_state_e state;
  pbl_pkg::pbl_state_e next_state;

  logic [7:0] hi;
  logic [7:0] lo;
  logic [4:0] pfx;
  logic       taken;
  logic       is_op;
  logic       op_or;
  logic       op_neg;
  logic [2:0] op_area;
  logic [pbl_pkg::ADDR_W-1:0] op_addr;
  logic [pbl_pkg::BIT_W-1:0]  op_bit;
  logic       is_sbit;
  logic       formal_bad;

  logic       pend_or;
  logic       pend_neg;
  logic       pend_formal;
  logic [pbl_pkg::BIT_W-1:0] pend_bit;
  logic       oper_bit;
  logic       or_acc;
  logic       rlo;

  logic       stk_or    [pbl_pkg::NEST_MAX];
  logic       stk_rlo   [pbl_pkg::NEST_MAX];
  logic       stk_first [pbl_pkg::NEST_MAX];
  logic       stk_kind  [pbl_pkg::NEST_MAX];
  logic [2:0] top;

  assign hi    = instr_word[pbl_pkg::HI_MSB:pbl_pkg::HI_LSB];
  assign lo    = instr_word[pbl_pkg::LO_MSB:0];
  assign pfx   = instr_word[pbl_pkg::HI_MSB:pbl_pkg::PFX_LSB];
  assign taken = instr_valid && instr_ready;
  assign top   = nest_depth - 3'h1;

  // Operand decode from the opcode word.
  always_comb begin
    is_op   = 1'b1;
    op_or   = 1'b0;
    op_neg  = 1'b0;
    op_area = pbl_pkg::PBL_AREA_INPUT;
    op_addr = '0;
    op_bit  = instr_word[pbl_pkg::BITF_MSB:pbl_pkg::BITF_LSB];
    is_sbit = 1'b0;
    case (pfx)
      pbl_pkg::PFX_IO_AND, pbl_pkg::PFX_IO_ANDN, pbl_pkg::PFX_IO_OR,
      pbl_pkg::PFX_IO_ORN: begin
        op_area = instr_word[pbl_pkg::IO_OUT_POS] ? pbl_pkg::PBL_AREA_OUTPUT
                                                   : pbl_pkg::PBL_AREA_INPUT;
        op_addr = {3'h0, instr_word[pbl_pkg::IO_BYTE_MSB:0]};
        op_or   = (pfx == pbl_pkg::PFX_IO_OR) || (pfx == pbl_pkg::PFX_IO_ORN);
        op_neg  = (pfx == pbl_pkg::PFX_IO_ANDN) || (pfx == pbl_pkg::PFX_IO_ORN);
      end
      pbl_pkg::PFX_MEM_AND, pbl_pkg::PFX_MEM_ANDN, pbl_pkg::PFX_MEM_OR,
      pbl_pkg::PFX_MEM_ORN: begin
        op_area = pbl_pkg::PBL_AREA_MEMORY;
        op_addr = {2'h0, lo};
        op_or   = (pfx == pbl_pkg::PFX_MEM_OR) || (pfx == pbl_pkg::PFX_MEM_ORN);
        op_neg  = (pfx == pbl_pkg::PFX_MEM_ANDN) || (pfx == pbl_pkg::PFX_MEM_ORN);
      end
      default: begin
        op_bit  = '0;
        op_addr = {3'h0, lo[pbl_pkg::IO_BYTE_MSB:0]};
        case (hi)
          pbl_pkg::HI_TMR_AND, pbl_pkg::HI_TMR_ANDN, pbl_pkg::HI_TMR_OR,
          pbl_pkg::HI_TMR_ORN: begin
            op_area = pbl_pkg::PBL_AREA_TIMER;
            op_or   = (hi == pbl_pkg::HI_TMR_OR) || (hi == pbl_pkg::HI_TMR_ORN);
            op_neg  = (hi == pbl_pkg::HI_TMR_ANDN) || (hi == pbl_pkg::HI_TMR_ORN);
          end
          pbl_pkg::HI_CNT_AND, pbl_pkg::HI_CNT_ANDN, pbl_pkg::HI_CNT_OR,
          pbl_pkg::HI_CNT_ORN: begin
            op_area = pbl_pkg::PBL_AREA_COUNTER;
            op_or   = (hi == pbl_pkg::HI_CNT_OR) || (hi == pbl_pkg::HI_CNT_ORN);
            op_neg  = (hi == pbl_pkg::HI_CNT_ANDN) || (hi == pbl_pkg::HI_CNT_ORN);
          end
          pbl_pkg::HI_FORMAL_AND: begin
            op_area = pbl_pkg::PBL_AREA_FORMAL;
            op_addr = {2'h0, lo};
          end
          default: begin
            is_op = 1'b0;
            case (instr_word)
              pbl_pkg::OPC_SBIT_AND, pbl_pkg::OPC_SBIT_ANDN: begin
                is_sbit = 1'b1;
                op_neg  = (instr_word == pbl_pkg::OPC_SBIT_ANDN);
              end
              pbl_pkg::OPC_SBIT_OR, pbl_pkg::OPC_SBIT_ORN: begin
                is_sbit = 1'b1;
                op_or   = 1'b1;
                op_neg  = (instr_word == pbl_pkg::OPC_SBIT_ORN);
              end
              default: is_sbit = 1'b0;
            endcase
          end
        endcase
      end
    endcase
  end

  // Formal operand refused outside a block.
  assign formal_bad = is_op && (op_area == pbl_pkg::PBL_AREA_FORMAL) && !in_fb;

  always_comb begin
    next_state = state;
    case (state)
      pbl_pkg::PBL_ST_IDLE: begin
        if (taken && is_sbit)
          next_state = pbl_pkg::PBL_ST_SADDR;
        else if (taken && is_op && !formal_bad)
          next_state = pbl_pkg::PBL_ST_REQ;
      end
      pbl_pkg::PBL_ST_SADDR: if (taken) next_state = pbl_pkg::PBL_ST_REQ;
      pbl_pkg::PBL_ST_REQ:   next_state = pbl_pkg::PBL_ST_WAIT;
      pbl_pkg::PBL_ST_WAIT:  next_state = pbl_pkg::PBL_ST_IDLE;
      default:               next_state = pbl_pkg::PBL_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= pbl_pkg::PBL_ST_IDLE;
      instr_ready <= 1'b1;
      rd_req      <= 1'b0;
    end else begin
      state       <= next_state;
      instr_ready <= (next_state == pbl_pkg::PBL_ST_IDLE) ||
                     (next_state == pbl_pkg::PBL_ST_SADDR);
      rd_req      <= (next_state == pbl_pkg::PBL_ST_REQ);
    end
  end

  // Operand address and pending operation.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_area     <= pbl_pkg::PBL_AREA_INPUT;
      rd_addr     <= '0;
      pend_bit    <= '0;
      pend_or     <= 1'b0;
      pend_neg    <= 1'b0;
      pend_formal <= 1'b0;
    end else if (taken && state == pbl_pkg::PBL_ST_IDLE && (is_op || is_sbit)) begin
      rd_area     <= is_sbit ? pbl_pkg::PBL_AREA_SBIT : op_area;
      rd_addr     <= op_addr;
      pend_bit    <= op_bit;
      pend_or     <= op_or;
      pend_neg    <= op_neg;
      pend_formal <= (op_area == pbl_pkg::PBL_AREA_FORMAL) && is_op;
    end else if (taken && state == pbl_pkg::PBL_ST_SADDR) begin
      // S-bit byte and bit from the address word.
      rd_addr  <= instr_word[pbl_pkg::SB_BYTE_MSB:pbl_pkg::SB_BYTE_LSB];
      pend_bit <= instr_word[pbl_pkg::SB_BIT_MSB:0];
    end
  end

  pbl_bit_pick #(
    .WIDTH (8)
  ) u_pick (
    .data    (rd_data),
    .sel     (pend_bit),
    .invert  (pend_neg),
    .bit_out (oper_bit)
  );

  // Logic result chain and bracket stack.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rlo          <= 1'b0;
      or_acc       <= 1'b0;
      first_query  <= 1'b1;
      logic_result <= 1'b0;
      nest_depth   <= '0;
      instr_error  <= 1'b0;
      for (int i = 0; i < pbl_pkg::NEST_MAX; i++) begin
        stk_or[i]    <= 1'b0;
        stk_rlo[i]   <= 1'b0;
        stk_first[i] <= 1'b0;
        stk_kind[i]  <= 1'b0;
      end
    end else begin
      instr_error  <= 1'b0;
      logic_result <= or_acc | rlo;
      if (rlo_restart) begin
        first_query <= 1'b1;
        or_acc      <= 1'b0;
      end else if (state == pbl_pkg::PBL_ST_WAIT) begin
        if (pend_formal && !rd_bit_type) begin
          instr_error <= 1'b1;
        end else begin
          first_query <= 1'b0;
          if (first_query)
            rlo <= oper_bit;
          else if (pend_or)
            rlo <= rlo | oper_bit;
          else
            rlo <= rlo & oper_bit;
        end
      end else if (taken && state == pbl_pkg::PBL_ST_IDLE) begin
        instr_error <= formal_bad;
        case (instr_word)
          pbl_pkg::OPC_OR_ANDS: begin
            or_acc      <= or_acc | rlo;
            rlo         <= 1'b0;
            first_query <= 1'b1;
          end
          pbl_pkg::OPC_AND_OPEN, pbl_pkg::OPC_OR_OPEN: begin
            if (nest_depth == pbl_pkg::NEST_MAX_D) begin
              instr_error <= 1'b1;
            end else begin
              stk_or[nest_depth]    <= or_acc;
              stk_rlo[nest_depth]   <= rlo;
              stk_first[nest_depth] <= first_query;
              stk_kind[nest_depth]  <= (instr_word == pbl_pkg::OPC_OR_OPEN);
              nest_depth  <= nest_depth + 3'h1;
              or_acc      <= 1'b0;
              rlo         <= 1'b0;
              first_query <= 1'b1;
            end
          end
          // Close and combine with outer result.
          pbl_pkg::OPC_CLOSE: begin
            if (nest_depth == 3'h0) begin
              instr_error <= 1'b1;
            end else begin
              nest_depth  <= top;
              or_acc      <= stk_or[top];
              first_query <= 1'b0;
              if (stk_first[top])
                rlo <= or_acc | rlo;
              else if (stk_kind[top])
                rlo <= stk_rlo[top] | or_acc | rlo;
              else
                rlo <= stk_rlo[top] & (or_acc | rlo);
            end
          end
          default: rlo <= rlo;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator1 <= '0;
      accumulator2 <= '0;
    end else if (load_valid) begin
      accumulator2 <= accumulator1;
      accumulator1 <= load_word;
    end else if (taken && state == pbl_pkg::PBL_ST_IDLE &&
                 instr_word == pbl_pkg::OPC_WORD_XOR) begin
      accumulator1 <= accumulator2 ^ accumulator1;
    end
  end

endmodule

/* design/pbl_pkg.sv */
// Constants and types shared by the bit-logic decoder files.
package pbl_pkg;

  localparam int WORD_W = 16;
  localparam int ADDR_W = 10;
  localparam int BIT_W  = 3;
  localparam int NEST_MAX = 6;
  localparam logic [2:0] NEST_MAX_D = 3'h6;

  // Whole-word opcodes.
  localparam logic [15:0] OPC_WORD_XOR   = 16'h5100;
  localparam logic [15:0] OPC_OR_ANDS    = 16'hFB00;
  localparam logic [15:0] OPC_AND_OPEN   = 16'hBA00;
  localparam logic [15:0] OPC_OR_OPEN    = 16'hBB00;
  localparam logic [15:0] OPC_CLOSE      = 16'hBF00;
  localparam logic [15:0] OPC_SBIT_AND   = 16'h780B;
  localparam logic [15:0] OPC_SBIT_ANDN  = 16'h784B;
  localparam logic [15:0] OPC_SBIT_OR    = 16'h781B;
  localparam logic [15:0] OPC_SBIT_ORN   = 16'h785B;

  // High-byte prefixes; the low three bits of the I/O and memory forms hold the bit index.
  localparam logic [4:0] PFX_IO_AND   = 5'h18;
  localparam logic [4:0] PFX_IO_ANDN  = 5'h1C;
  localparam logic [4:0] PFX_IO_OR    = 5'h19;
  localparam logic [4:0] PFX_IO_ORN   = 5'h1D;
  localparam logic [4:0] PFX_MEM_AND  = 5'h10;
  localparam logic [4:0] PFX_MEM_ANDN = 5'h14;
  localparam logic [4:0] PFX_MEM_OR   = 5'h11;
  localparam logic [4:0] PFX_MEM_ORN  = 5'h15;
  localparam logic [7:0] HI_TMR_AND   = 8'hF8;
  localparam logic [7:0] HI_TMR_ANDN  = 8'hFC;
  localparam logic [7:0] HI_TMR_OR    = 8'hF9;
  localparam logic [7:0] HI_TMR_ORN   = 8'hFD;
  localparam logic [7:0] HI_CNT_AND   = 8'hB8;
  localparam logic [7:0] HI_CNT_ANDN  = 8'hBC;
  localparam logic [7:0] HI_CNT_OR    = 8'hB9;
  localparam logic [7:0] HI_CNT_ORN   = 8'hBD;
  localparam logic [7:0] HI_FORMAL_AND = 8'h07;

  // Field positions inside opcode words.
  localparam int HI_MSB   = 15;
  localparam int HI_LSB   = 8;
  localparam int PFX_LSB  = 11;
  localparam int BITF_MSB = 10;
  localparam int BITF_LSB = 8;
  localparam int IO_OUT_POS = 7;
  localparam int IO_BYTE_MSB = 6;
  localparam int LO_MSB   = 7;
  localparam int SB_BYTE_MSB = 12;
  localparam int SB_BYTE_LSB = 3;
  localparam int SB_BIT_MSB  = 2;

  // Operand areas presented on the read port.
  typedef enum logic [2:0] {
    PBL_AREA_INPUT   = 3'h0,
    PBL_AREA_OUTPUT  = 3'h1,
    PBL_AREA_MEMORY  = 3'h2,
    PBL_AREA_SBIT    = 3'h3,
    PBL_AREA_TIMER   = 3'h4,
    PBL_AREA_COUNTER = 3'h5,
    PBL_AREA_FORMAL  = 3'h6
  } pbl_area_e;

  typedef enum logic [3:0] {
    PBL_ST_IDLE  = 4'b0001,
    PBL_ST_SADDR = 4'b0010,
    PBL_ST_REQ   = 4'b0100,
    PBL_ST_WAIT  = 4'b1000
  } pbl_state_e;

endpackage

/* test/pbl_decoder_assertions.sv */
// Port-level checks for the bit-logic decoder.
`timescale 1ns/1ps
module pbl_decoder_assertions (
  input wire logic        clk,          // Clock
  input wire logic        rst_n,        // Reset
  input wire logic        instr_valid,  // Offer
  input wire logic [15:0] instr_word,   // Word
  input wire logic        instr_ready,  // Taken
  input wire logic        load_valid,   // Load
  input wire logic [15:0] load_word,    // Load word
  input wire logic        rlo_restart,  // Restart
  input wire logic        in_fb,        // In block
  input wire logic        rd_req,       // Read
  input wire logic [2:0]  rd_area,      // Area
  input wire logic [9:0]  rd_addr,      // Address
  input wire logic [7:0]  rd_data,      // Data
  input wire logic        rd_bit_type,  // Bit type
  input wire logic        logic_result, // Result
  input wire logic        first_query,  // First
  input wire logic [15:0] accumulator1, // Acc one
  input wire logic [15:0] accumulator2, // Acc two
  input wire logic [2:0]  nest_depth,   // Depth
  input wire logic        instr_error   // Error
);
  logic       sb_pend;
  logic       take;
  logic       opn;
  logic [7:0] hi;
  assign hi   = instr_word[15:8];
  assign take = instr_valid && instr_ready && !sb_pend;
  assign opn  = take && (hi == 8'hBA || hi == 8'hBB) && instr_word[7:0] == 8'h00;
  // The address word after an S-bit opcode must not be mistaken for an opcode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sb_pend <= 1'b0;
    end else if (instr_valid && instr_ready) begin
      sb_pend <= !sb_pend && (instr_word & 16'hFFAF) == pbl_pkg::OPC_SBIT_AND;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_xor_accum: assert property (take && instr_word == pbl_pkg::OPC_WORD_XOR
    && !load_valid |=> accumulator1 == $past(accumulator1 ^ accumulator2))
    else $error("xor result wrong");
  a_io_read: assert property (take && (instr_word[15:11] & 5'h1A) == pbl_pkg::PFX_IO_AND
    |=> rd_req && rd_area == {2'h0, $past(instr_word[7])}
    && rd_addr == {3'h0, $past(instr_word[6:0])})
    else $error("io read wrong");
  a_mem_read: assert property (take && (instr_word[15:11] & 5'h1A) == pbl_pkg::PFX_MEM_AND
    |=> rd_req && rd_area == 3'h2 && rd_addr == {2'h0, $past(instr_word[7:0])})
    else $error("memory read wrong");
  // Timer numbers stop at 127, so only seven bits of the number field reach the address.
  a_timer_read: assert property (take && (hi & 8'hFA) == pbl_pkg::HI_TMR_AND
    |=> rd_req && rd_area == 3'h4 && rd_addr == {3'h0, $past(instr_word[6:0])})
    else $error("timer read wrong");
  a_sbit_read: assert property (sb_pend && instr_valid && instr_ready
    |=> rd_req && rd_area == 3'h3 && rd_addr == $past(instr_word[12:3]))
    else $error("sbit read wrong");
  a_read_stall: assert property (rd_req
    |-> !instr_ready ##1 (!instr_ready && !rd_req) ##1 instr_ready)
    else $error("read stall wrong");
  a_open_depth: assert property (opn && nest_depth < pbl_pkg::NEST_MAX_D
    |=> nest_depth == $past(nest_depth) + 3'h1) else $error("open depth wrong");
  a_open_limit: assert property (opn && nest_depth == pbl_pkg::NEST_MAX_D
    |=> nest_depth == pbl_pkg::NEST_MAX_D ##[0:1] instr_error) else $error("depth limit wrong");
  a_formal_gate: assert property (take && hi == pbl_pkg::HI_FORMAL_AND && !in_fb
    |=> !rd_req && instr_error) else $error("formal outside block");
endmodule

/* test/pbl_operand_store.sv */
// Operand store model answering the decoder read port one cycle after a request.
`timescale 1ns/1ps
module pbl_operand_store (
  input  wire logic       clk,         // Clock
  input  wire logic       rst_n,       // Reset
  input  wire logic       rd_req,      // Read strobe
  input  wire logic [2:0] rd_area,     // Area
  input  wire logic [9:0] rd_addr,     // Address
  output logic      [7:0] rd_data,     // Operand byte
  output logic            rd_bit_type  // Bit type
);
  logic [7:0] store [0:6][0:1023];
  logic       bit_type [0:1023];
  // Lines toggle outside the answer cycle so that a late sample is caught.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data     <= 8'h00;
      rd_bit_type <= 1'b0;
    end else if (rd_req) begin
      rd_data     <= store[rd_area][rd_addr];
      rd_bit_type <= bit_type[rd_addr];
    end else begin
      rd_data     <= ~rd_data;
      rd_bit_type <= ~rd_bit_type;
    end
  end
endmodule

/* test/tb_top.sv */
// Self-checking bench for the bit-logic decoder.
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_n, instr_valid, load_valid, rlo_restart, in_fb;
  logic [15:0] instr_word, load_word, accumulator1, accumulator2, a16, b16;
  logic        instr_ready, rd_req, rd_bit_type, logic_result, first_query, instr_error;
  logic [2:0]  rd_area, nest_depth;
  logic [9:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        or_acc, term, fq;
  logic [3:0]  stk [$];
  int          error_cnt = 0, comparisons = 0, errs_seen = 0, errs_exp = 0;
  time         t_drop = 0;
  pbl_decoder dut_u (.clk, .rst_n, .instr_valid, .instr_word, .instr_ready, .load_valid,
    .load_word, .rlo_restart, .in_fb, .rd_req, .rd_area, .rd_addr, .rd_data, .rd_bit_type,
    .logic_result, .first_query, .accumulator1, .accumulator2, .nest_depth, .instr_error);
  pbl_operand_store part_u (.clk, .rst_n, .rd_req, .rd_area, .rd_addr, .rd_data, .rd_bit_type);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Error pulses are counted at the falling edge, where they have settled.
  always @(negedge clk) if (instr_error === 1'b1) errs_seen++;
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (instr_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n == 50) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic issue(input logic [15:0] w);
    // A word that follows another at once lets one edge pass, so valid never toggles in a step.
    if (t_drop == $time) @(negedge clk);
    wait_ready();
    instr_valid = 1'b1;
    instr_word  = w;
    @(negedge clk);
    instr_valid = 1'b0;
    t_drop      = $time;
  endtask
  task automatic result_chk();
    wait_ready();
    @(negedge clk);
    check("logic_result", 16'(logic_result), 16'(or_acc | term));
  endtask
  task automatic restart();
    rlo_restart = 1'b1;
    @(negedge clk);
    rlo_restart = 1'b0;
    or_acc = 1'b0;
    fq = 1'b1;
    stk.delete();
  endtask
  task automatic combine(input logic kor, input logic v);
    term = fq ? v : (kor ? term | v : term & v);
    fq = 1'b0;
  endtask
  task automatic operand(input int a, input logic kor, input logic kn, input logic [9:0] ad,
                         input logic [2:0] bn);
    logic [15:0] w;
    logic [7:0]  b;
    b = part_u.store[a][ad];
    case (a)
      0, 1: w = {pbl_pkg::PFX_IO_AND | {2'h0, kn, 1'b0, kor}, bn, a[0], ad[6:0]};
      2: w = {pbl_pkg::PFX_MEM_AND | {2'h0, kn, 1'b0, kor}, bn, ad[7:0]};
      3: w = pbl_pkg::OPC_SBIT_AND | {9'h0, kn, 1'b0, kor, 4'h0};
      4: w = {pbl_pkg::HI_TMR_AND | {5'h0, kn, 1'b0, kor}, 1'b0, ad[6:0]};
      default: w = {pbl_pkg::HI_CNT_AND | {5'h0, kn, 1'b0, kor}, 1'b0, ad[6:0]};
    endcase
    issue(w);
    if (a == 3) issue({3'h0, ad, bn});
    combine(kor, (a > 3 ? b[0] : b[bn]) ^ kn);
    result_chk();
  endtask
  task automatic rnd_op(input logic kor);
    operand($urandom_range(0, 5), kor, 1'($urandom_range(0, 1)), 10'($urandom_range(0, 127)),
            3'($urandom_range(0, 7)));
  endtask
  task automatic bracket(input logic [15:0] w);
    logic [3:0] top;
    logic       inner;
    issue(w);
    if (w == pbl_pkg::OPC_CLOSE) begin
      inner = or_acc | term;
      top = stk.pop_back();
      {or_acc, term, fq} = top[3:1];
      combine(top[0], inner);
      result_chk();
    end else begin
      stk.push_back({or_acc, term, fq, w == pbl_pkg::OPC_OR_OPEN});
      or_acc = 1'b0;
      fq = 1'b1;
    end
  endtask
  task automatic load(input logic [15:0] w);
    load_word  = w;
    load_valid = 1'b1;
    @(negedge clk);
    load_valid = 1'b0;
    @(negedge clk);
  endtask
  // Tests need well under 6000 cycles; ten times that means a hang.
  initial begin
    #3000000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {rst_n, instr_valid, load_valid, rlo_restart, in_fb} = 5'h00;
    instr_word = 16'h0000;
    load_word = 16'h0000;
    void'($urandom(34916));
    for (int a = 0; a < 7; a++) for (int i = 0; i < 1024; i++) part_u.store[a][i] = 8'($urandom);
    for (int i = 0; i < 1024; i++) part_u.bit_type[i] = 1'b1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("first_query", 16'(first_query), 16'h0001);
    restart();
    operand(0, 1'b0, 1'b0, 10'h07F, 3'h7);
    operand(1, 1'b0, 1'b1, 10'h07F, 3'h7);
    operand(3, 1'b0, 1'b0, 10'h3FF, 3'h7);
    operand(3, 1'b1, 1'b1, 10'h200, 3'h3);
    operand(5, 1'b0, 1'b0, 10'h000, 3'h0);
    operand(2, 1'b1, 1'b0, 10'h0FF, 3'h7);
    operand(4, 1'b1, 1'b1, 10'h07F, 3'h0);
    for (int r = 0; r < 3; r++) for (int a = 0; a < 6; a++) for (int k = 0; k < 4; k++) begin
      restart();
      rnd_op(1'b0);
      operand(a, k[0], k[1], 10'($urandom_range(0, a == 3 ? 1023 : a == 2 ? 255 : 127)),
              3'($urandom_range(0, 7)));
    end
    $display("test operands done");
    for (int r = 0; r < 10; r++) begin
      restart();
      repeat ($urandom_range(1, 3)) rnd_op(1'b0);
      issue(pbl_pkg::OPC_OR_ANDS);
      or_acc = or_acc | term;
      fq = 1'b1;
      repeat ($urandom_range(1, 3)) rnd_op(1'b0);
    end
    for (int r = 0; r < 4; r++) begin
      restart();
      rnd_op(1'b0);
      bracket(r[0] ? pbl_pkg::OPC_OR_OPEN : pbl_pkg::OPC_AND_OPEN);
      bracket(pbl_pkg::OPC_OR_OPEN);
      rnd_op(1'b0);
      rnd_op(1'b0);
      bracket(pbl_pkg::OPC_CLOSE);
      rnd_op(r[1]);
      bracket(pbl_pkg::OPC_CLOSE);
    end
    $display("test chains done");
    restart();
    for (int d = 1; d < 15; d++) begin
      issue(d > 7 ? pbl_pkg::OPC_CLOSE : d[0] ? pbl_pkg::OPC_AND_OPEN : pbl_pkg::OPC_OR_OPEN);
      @(negedge clk);
      check("nest_depth", 16'(nest_depth),
            16'(d > 7 ? (d > 12 ? 0 : 13 - d) : d > 6 ? 6 : d));
    end
    errs_exp += 2;
    repeat (3) @(negedge clk);
    check("errors", 16'(errs_seen), 16'(errs_exp));
    $display("test depth done");
    for (int i = 0; i < 4; i++) begin
      a16 = 16'($urandom);
      b16 = i == 0 ? a16 : 16'($urandom);
      load(b16);
      load(a16);
      issue(pbl_pkg::OPC_WORD_XOR);
      @(negedge clk);
      check("accumulator1", accumulator1, a16 ^ b16);
      check("accumulator2", accumulator2, b16);
    end
    $display("test xor done");
    in_fb = 1'b1;
    part_u.bit_type[9] = 1'b0;
    restart();
    rnd_op(1'b0);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) in_fb = 1'b0;
      issue({pbl_pkg::HI_FORMAL_AND, i == 1 ? 8'h09 : 8'h05});
      if (i == 0) combine(1'b0, part_u.store[6][5][0]);
      else errs_exp++;
      result_chk();
      check("errors", 16'(errs_seen), 16'(errs_exp));
    end
    $display("test formal done");
    wrap_up();
  end
endmodule
bind pbl_decoder pbl_decoder_assertions chk_u (.clk, .rst_n, .instr_valid, .instr_word,
  .instr_ready, .load_valid, .load_word, .rlo_restart, .in_fb, .rd_req, .rd_area, .rd_addr,
  .rd_data, .rd_bit_type, .logic_result, .first_query, .accumulator1, .accumulator2,
  .nest_depth, .instr_error);
